// [hdl/cmd_decode_pkg.sv]
// constants for the per-channel command register decoder
// assumes one bus clock shared by host write port and channel logic
// Operation
// - code 00 takes no crc action
// - code 01 restarts receive crc checker
// - receiver disable or sdlc-mode frame gap restarts checker
// - code 10 restarts transmit crc; reset doesn't
// - code 11 clears latch; underrun then appends crc
// - sdlc abort-on-underrun with latch clear sends abort
// - crc start sets latch, winning over a same-cycle clear
// - tx disabled: latch kept, status interrupt raised
// - command 000 does nothing
// - command 001 adds eight to pointer in non-muxed mode
// - status bits latch; 010 re-enables them
// - persisting queued change interrupts again after reset
// - 011 sends abort in sdlc mode only, empties buffer, sets latch
// - 100 re-arms first-character receive interrupt
// - 101 clears tx pending until load or crc
// - 110 clears errors and releases held data
// - held special data discarded if reset first
// - 111 clears highest interrupt-under-service bit
// - non-muxed: low bits select registers 0-7
// - muxed: 10 shift left, 11 shift right
package cmd_decode_pkg;
  localparam int CRC_MSB = 7;
  localparam int CRC_LSB = 6;
  localparam int CMD_MSB = 5;
  localparam int CMD_LSB = 3;
  localparam int PTR_MSB = 2;
  localparam int PTR_LSB = 0;
  localparam int PTR_W   = 4;

  typedef enum logic [1:0] {
    CRC_NULL     = 2'b00,
    CRC_RX_RST   = 2'b01,
    CRC_TX_RST   = 2'b10,
    CRC_EOM_CLR  = 2'b11
  } crc_code_t;

  typedef enum logic [2:0] {
    CMD_NULL     = 3'b000,
    CMD_POINT_HI = 3'b001,
    CMD_EXT_RST  = 3'b010,
    CMD_ABORT    = 3'b011,
    CMD_RX_FIRST = 3'b100,
    CMD_TX_PEND  = 3'b101,
    CMD_ERR_RST  = 3'b110,
    CMD_IUS_RST  = 3'b111
  } cmd_code_t;

  localparam logic [1:0] SHIFT_LEFT  = 2'b10;
  localparam logic [1:0] SHIFT_RIGHT = 2'b11;
  localparam logic [3:0] HIGH_BANK   = 4'h8;
  localparam logic [3:0] PTR_RST     = 4'h0;
endpackage : cmd_decode_pkg

// [hdl/serial_channel_command_decode.sv]
// per-channel command register decoder with eom and status latches
// assumes host writes are one-cycle strobes synchronous to clk_i
`timescale 1ns/10ps
module serial_channel_command_decode (
  input  wire logic       clk_i,            // bus clock
  input  wire logic       sys_rst_i,        // async reset, high
  input  wire logic       wr_i,             // command write strobe
  input  wire logic [7:0] wdata_i,          // command byte
  input  wire logic       muxed_bus_i,      // multiplexed bus mode
  input  wire logic       ptr_done_i,       // pointer used by access
  input  wire logic       sdlc_mode_i,      // bit-oriented mode
  input  wire logic       abort_on_urun_i,  // abort on underrun
  input  wire logic       tx_enable_i,      // transmitter enabled
  input  wire logic       rx_enable_i,      // receiver enabled
  input  wire logic       frame_end_i,      // sdlc frame boundary
  input  wire logic       tx_underrun_i,    // transmitter underrun
  input  wire logic       crc_start_i,      // crc sending begins
  input  wire logic       crc_done_i,       // crc fully sent
  input  wire logic       tx_load_i,        // char loaded to buffer
  input  wire logic       tx_empty_i,       // transmit buffer empty
  input  wire logic       ext_change_i,     // raw status change
  input  wire logic [7:0] ext_status_i,     // live status bits
  input  wire logic       special_cond_i,   // special rx condition
  input  wire logic       rx_special_mode_i,// first/special int mode
  output logic [3:0]      reg_ptr_o,        // next register select
  output logic            shift_left_o,     // muxed shift left
  output logic            shift_right_o,    // muxed shift right
  output logic            rx_crc_init_o,    // receive crc init pulse
  output logic            tx_crc_init_o,    // transmit crc init pulse
  output logic            eom_latch_o,      // underrun/eom latch
  output logic            append_crc_o,     // append crc pulse
  output logic            send_abort_o,     // abort then flag pulse
  output logic            abort_ones_o,     // abort ones command
  output logic            tx_flush_o,       // empty transmit buffer
  output logic [7:0]      ext_latched_o,    // latched status bits
  output logic            ext_int_o,        // status interrupt pend
  output logic            rx_first_arm_o,   // first char re-armed
  output logic            tx_int_o,         // tx interrupt pending
  output logic            err_clear_o,      // clear error bits
  output logic            rx_hold_o,        // fifo held on special
  output logic            rx_discard_o,     // discard held data
  output logic            ius_clear_o       // clear highest ius
);
  logic [1:0] crc;
  logic [2:0] cmd;
  logic [2:0] low;
  assign crc = wr_i ? wdata_i[cmd_decode_pkg::CRC_MSB:
                              cmd_decode_pkg::CRC_LSB] : 2'b00;
  assign cmd = wr_i ? wdata_i[cmd_decode_pkg::CMD_MSB:
                              cmd_decode_pkg::CMD_LSB] : 3'b000;
  assign low = wdata_i[cmd_decode_pkg::PTR_MSB:cmd_decode_pkg::PTR_LSB];

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  typedef cmd_decode_pkg::crc_code_t crc_code_t;
  typedef cmd_decode_pkg::cmd_code_t cmd_code_t;
  logic c_rx, c_tx, c_eom, c_hi, c_ext, c_abt, c_first, c_txp, c_err;
  logic c_ius;
  always_comb begin
    c_rx = 1'b0;
    c_tx = 1'b0;
    c_eom = 1'b0;
    unique case (crc_code_t'(crc))
      cmd_decode_pkg::CRC_NULL:    ;
      cmd_decode_pkg::CRC_RX_RST:  c_rx = 1'b1;
      cmd_decode_pkg::CRC_TX_RST:  c_tx = 1'b1;
      cmd_decode_pkg::CRC_EOM_CLR: c_eom = 1'b1;
    endcase
    c_hi = 1'b0;
    c_ext = 1'b0;
    c_abt = 1'b0;
    c_first = 1'b0;
    c_txp = 1'b0;
    c_err = 1'b0;
    c_ius = 1'b0;
    unique case (cmd_code_t'(cmd))
      cmd_decode_pkg::CMD_NULL:     ;
      cmd_decode_pkg::CMD_POINT_HI: c_hi = 1'b1;
      cmd_decode_pkg::CMD_EXT_RST:  c_ext = 1'b1;
      cmd_decode_pkg::CMD_ABORT:    c_abt = 1'b1;
      cmd_decode_pkg::CMD_RX_FIRST: c_first = 1'b1;
      cmd_decode_pkg::CMD_TX_PEND:  c_txp = 1'b1;
      cmd_decode_pkg::CMD_ERR_RST:  c_err = 1'b1;
      cmd_decode_pkg::CMD_IUS_RST:  c_ius = 1'b1;
    endcase
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic [3:0] ptr_q, ptr_d;
  logic       sl_q, sl_d, sr_q, sr_d;
  logic       rxen_q;
  logic       rxi_q, rxi_d, txi_q, txi_d, eomc_q, eomc_d, abt_q, abt_d;
  logic       eom_q, eom_d, tx_q, tx_d, ext_q, ext_d, arm_q, arm_d;
  logic       txs_q, txs_d, hold_q, hold_d, err_q, err_d, disc_q, disc_d;
  logic       ius_q, ius_d, flush_q, flush_d, ab1_q, ab1_d;
  logic       queued_q, queued_d;
  logic [7:0] lat_q, lat_d;
  always_comb begin
    ptr_d = ptr_q;
    sl_d  = 1'b0;
    sr_d  = 1'b0;
    if (ptr_done_i) ptr_d = cmd_decode_pkg::PTR_RST;
    if (wr_i && muxed_bus_i) begin
      sl_d = (low[1:0] == cmd_decode_pkg::SHIFT_LEFT);
      sr_d = (low[1:0] == cmd_decode_pkg::SHIFT_RIGHT);
    end else if (wr_i) begin
      ptr_d = {1'b0, low} | (c_hi ? cmd_decode_pkg::HIGH_BANK
                                  : cmd_decode_pkg::PTR_RST);
    end
    rxi_d = c_rx || (rxen_q && !rx_enable_i)
            || (sdlc_mode_i && frame_end_i);
    txi_d = c_tx;
    eom_d = eom_q;
    if (c_eom && tx_enable_i) eom_d = 1'b0;
    if (crc_start_i || c_abt) eom_d = 1'b1;
    eomc_d = tx_underrun_i && !eom_q
             && !(sdlc_mode_i && abort_on_urun_i);
    abt_d  = tx_underrun_i && !eom_q
             && sdlc_mode_i && abort_on_urun_i;
    ab1_d   = c_abt && sdlc_mode_i;
    flush_d = c_abt;
    // status latch: freeze on interrupt, queue further changes
    ext_d = ext_q;
    lat_d = lat_q;
    queued_d = queued_q;
    if (!ext_q) lat_d = ext_status_i;
    if (ext_q && ext_change_i) queued_d = 1'b1;
    if (c_ext) begin
      ext_d = 1'b0;
      lat_d = ext_status_i;
      queued_d = 1'b0;
      if (queued_q && (ext_status_i != lat_q)) ext_d = 1'b1;
    end
    if (!ext_q && ext_change_i) ext_d = 1'b1;
    if (c_eom && !tx_enable_i && (!ext_q || c_ext)) begin
      ext_d = 1'b1;
      lat_d = ext_status_i;
    end
    arm_d = arm_q;
    if (c_first) arm_d = 1'b1;
    else if (special_cond_i) arm_d = 1'b0;
    txs_d = txs_q;
    if (c_txp) txs_d = 1'b1;
    if (tx_load_i || crc_done_i) txs_d = 1'b0;
    tx_d = tx_empty_i && tx_enable_i && !txs_d;
    hold_d = hold_q;
    if (special_cond_i && rx_special_mode_i) hold_d = 1'b1;
    else if (c_err) hold_d = 1'b0;
    err_d  = c_err;
    disc_d = c_err && hold_q;
    ius_d  = c_ius;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ptr_q <= cmd_decode_pkg::PTR_RST;
      sl_q <= 1'b0;
      sr_q <= 1'b0;
      rxen_q <= 1'b0;
      rxi_q <= 1'b0;
      txi_q <= 1'b0;
      eomc_q <= 1'b0;
      abt_q <= 1'b0;
      eom_q <= 1'b1;
      tx_q <= 1'b0;
      ext_q <= 1'b0;
      arm_q <= 1'b0;
      txs_q <= 1'b0;
      hold_q <= 1'b0;
      err_q <= 1'b0;
      disc_q <= 1'b0;
      ius_q <= 1'b0;
      flush_q <= 1'b0;
      ab1_q <= 1'b0;
      queued_q <= 1'b0;
      lat_q <= 8'h00;
    end else begin
      ptr_q <= ptr_d;
      sl_q <= sl_d;
      sr_q <= sr_d;
      rxen_q <= rx_enable_i;
      rxi_q <= rxi_d;
      txi_q <= txi_d;
      eomc_q <= eomc_d;
      abt_q <= abt_d;
      eom_q <= eom_d;
      tx_q <= tx_d;
      ext_q <= ext_d;
      arm_q <= arm_d;
      txs_q <= txs_d;
      hold_q <= hold_d;
      err_q <= err_d;
      disc_q <= disc_d;
      ius_q <= ius_d;
      flush_q <= flush_d;
      ab1_q <= ab1_d;
      queued_q <= queued_d;
      lat_q <= lat_d;
    end
  end

  assign reg_ptr_o      = ptr_q;
  assign shift_left_o   = sl_q;
  assign shift_right_o  = sr_q;
  assign rx_crc_init_o  = rxi_q;
  assign tx_crc_init_o  = txi_q;
  assign eom_latch_o    = eom_q;
  assign append_crc_o   = eomc_q;
  assign send_abort_o   = abt_q;
  assign abort_ones_o   = ab1_q;
  assign tx_flush_o     = flush_q;
  assign ext_latched_o  = lat_q;
  assign ext_int_o      = ext_q;
  assign rx_first_arm_o = arm_q;
  assign tx_int_o       = tx_q;
  assign err_clear_o    = err_q;
  assign rx_hold_o      = hold_q;
  assign rx_discard_o   = disc_q;
  assign ius_clear_o    = ius_q;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  null_no_crc_a: assert property (wr_i && wdata_i[7:6] == 2'b00 |=>
    !rx_crc_init_o || $past(!rx_enable_i)
    || $past(sdlc_mode_i && frame_end_i)) else $error("null crc acted");
  rx_crc_a: assert property (wr_i && wdata_i[7:6] == 2'b01 |=>
    rx_crc_init_o) else $error("rx crc not reset");
  tx_crc_a: assert property (wr_i && wdata_i[7:6] == 2'b10 |=>
    tx_crc_init_o) else $error("tx crc not reset");
  eom_set_a: assert property (crc_start_i |=> eom_latch_o)
    else $error("eom latch not set");
  eom_keep_a: assert property (wr_i && wdata_i[7:6] == 2'b11
    && !tx_enable_i && !crc_start_i && eom_latch_o |=> eom_latch_o)
    else $error("latch cleared while disabled");
  point_hi_a: assert property (wr_i && !muxed_bus_i
    && wdata_i[5:3] == 3'b001 |=> reg_ptr_o == {1'b1, $past(low)})
    else $error("point high wrong");
  append_a: assert property (tx_underrun_i && !eom_latch_o
    && !sdlc_mode_i |=> append_crc_o) else $error("crc not appended");
  abort_a: assert property (wr_i && wdata_i[5:3] == 3'b011
    |=> tx_flush_o ##0 eom_latch_o) else $error("abort incomplete");
  ius_a: assert property (wr_i && wdata_i[5:3] == 3'b111 |=>
    ius_clear_o) else $error("ius not cleared");
  txp_a: assert property (txs_q && !tx_load_i && !crc_done_i
    |=> !tx_int_o) else $error("tx int not held off");
  null_no_tx_a: assert property (wr_i && wdata_i[7:6] == 2'b00
    |=> !tx_crc_init_o)
    else $error("null crc reset tx");
  rx_frame_a: assert property (sdlc_mode_i && frame_end_i
    |=> rx_crc_init_o)
    else $error("frame gap no crc init");
  rx_disable_a: assert property ($fell(rx_enable_i)
    |=> rx_crc_init_o)
    else $error("rx disable no crc init");
  eom_clear_a: assert property (wr_i && wdata_i[7:6] == 2'b11
    && tx_enable_i && !crc_start_i && wdata_i[5:3] != 3'b011
    |=> !eom_latch_o) else $error("eom latch not cleared");
  abort_urun_a: assert property (tx_underrun_i && !eom_latch_o
    && sdlc_mode_i && abort_on_urun_i |=> send_abort_o && !append_crc_o)
    else $error("underrun abort missing");
  eom_int_a: assert property (wr_i && wdata_i[7:6] == 2'b11
    && !tx_enable_i && !ext_int_o |=> ext_int_o)
    else $error("disabled clear no status int");
  ext_raise_a: assert property (!ext_int_o && ext_change_i
    |=> ext_int_o)
    else $error("status change no int");
  ext_freeze_a: assert property (ext_int_o
    && !(wr_i && wdata_i[5:3] == 3'b010) |=> $stable(ext_latched_o))
    else $error("latched status moved");
  rx_arm_a: assert property (wr_i && wdata_i[5:3] == 3'b100
    |=> rx_first_arm_o)
    else $error("first char not armed");
  tx_reload_a: assert property (tx_load_i && tx_empty_i
    && tx_enable_i |=> tx_int_o)
    else $error("tx int not restored");
  err_clear_a: assert property (wr_i && wdata_i[5:3] == 3'b110
    |=> err_clear_o)
    else $error("error bits not cleared");
  rx_hold_a: assert property (special_cond_i && rx_special_mode_i
    |=> rx_hold_o)
    else $error("special data not held");
  ptr_low_a: assert property (wr_i && !muxed_bus_i
    && wdata_i[5:3] != 3'b001 |=> reg_ptr_o == {1'b0, $past(low)})
    else $error("low pointer wrong");
  shift_sel_a: assert property (wr_i && muxed_bus_i
    && wdata_i[1:0] == 2'b10 |=> shift_left_o && !shift_right_o)
    else $error("shift left not decoded");

  // ------------------------------------------------------------------
  // cover points
  // ------------------------------------------------------------------
  abort_c:  cover property (send_abort_o);
  append_c: cover property (append_crc_o);
  queue_c:  cover property (ext_int_o ##1 !ext_int_o ##1 ext_int_o);
  disc_c:   cover property (rx_discard_o);
endmodule : serial_channel_command_decode

// [dv/host_cpu_model.sv]
// host side model that writes the command byte
// assumes the bench calls write_byte from one thread, one call at a time
`timescale 1ns/10ps
module host_cpu_model (
  input  wire logic       clk_i,    // bus clock
  input  wire logic       muxed_i,  // multiplexed bus mode
  output logic            wr_o,     // write strobe
  output logic [7:0]      wdata_o   // command byte
);
  initial begin
    wr_o    = 1'b0;
    wdata_o = 8'h00;
  end

  // one-cycle strobe; idle bus shows the inverse of the last byte
  task automatic write_byte(input logic [7:0] b);
    logic [7:0] v;
    v = b;
    @(posedge clk_i);
    if (muxed_i) begin
      v[2] = 1'b0;
    end
    wr_o    <= 1'b1;
    wdata_o <= v;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~v;
    #1;
  endtask : write_byte
endmodule : host_cpu_model

// [dv/tb_top.sv]
// self-checking bench for the command register decoder
// assumes registered outputs update on the taking edge and are read 1ns later
`timescale 1ns/10ps
module tb_top;
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       muxed_bus_i = 1'b0;
  logic       sdlc_mode_i = 1'b0;
  logic       abort_on_urun_i = 1'b0;
  logic       tx_enable_i = 1'b0;
  logic       rx_enable_i = 1'b1;
  logic       tx_empty_i = 1'b1;
  logic       rx_special_mode_i = 1'b0;
  logic [7:0] ext_status_i = 8'h00;
  logic [6:0] ev = 7'h00;
  logic       wr_w;
  logic [7:0] wdata_w;
  logic [3:0] reg_ptr_o;
  logic [7:0] ext_latched_o;
  logic       shift_left_o, shift_right_o, rx_crc_init_o, tx_crc_init_o;
  logic       eom_latch_o, append_crc_o, send_abort_o, abort_ones_o;
  logic       tx_flush_o, ext_int_o, rx_first_arm_o, tx_int_o;
  logic       err_clear_o, rx_hold_o, rx_discard_o, ius_clear_o;
  int         failures = 0;
  int         n_checks = 0;

  always #10 clk_i = ~clk_i;

  host_cpu_model u_host_cpu_model (.clk_i(clk_i), .muxed_i(muxed_bus_i),
    .wr_o(wr_w), .wdata_o(wdata_w));

  serial_channel_command_decode u_serial_channel_command_decode (
    .clk_i, .sys_rst_i, .wr_i(wr_w), .wdata_i(wdata_w), .muxed_bus_i,
    .ptr_done_i(1'b0), .sdlc_mode_i, .abort_on_urun_i, .tx_enable_i,
    .rx_enable_i, .frame_end_i(ev[0]), .tx_underrun_i(ev[1]),
    .crc_start_i(ev[2]), .crc_done_i(ev[3]), .tx_load_i(ev[4]),
    .tx_empty_i, .ext_change_i(ev[5]), .ext_status_i,
    .special_cond_i(ev[6]), .rx_special_mode_i, .reg_ptr_o,
    .shift_left_o, .shift_right_o, .rx_crc_init_o, .tx_crc_init_o,
    .eom_latch_o, .append_crc_o, .send_abort_o, .abort_ones_o,
    .tx_flush_o, .ext_latched_o, .ext_int_o, .rx_first_arm_o, .tx_int_o,
    .err_clear_o, .rx_hold_o, .rx_discard_o, .ius_clear_o);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] b);
    u_host_cpu_model.write_byte(b);
  endtask : wr

  task automatic pulse(input int k);
    @(posedge clk_i);
    ev[k] <= 1'b1;
    @(posedge clk_i);
    ev[k] <= 1'b0;
    #1;
  endtask : pulse

  task automatic give_verdict();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(eom_latch_o, 8'h01);
    wr(8'h05);
    chk(reg_ptr_o, 8'h05);
    wr(8'h4D);
    chk(reg_ptr_o, 8'h0D);
    wr(8'h00);
    chk({rx_crc_init_o, tx_crc_init_o, ius_clear_o}, 8'h00);
    $display("pointer test done");
    wr(8'hC0);
    chk(eom_latch_o, 8'h01);
    chk(ext_int_o, 8'h01);
    wr(8'h10);
    chk(ext_int_o, 8'h00);
    ext_status_i <= 8'h20;
    pulse(5);
    chk(ext_int_o, 8'h01);
    chk(ext_latched_o, 8'h20);
    ext_status_i <= 8'h30;
    pulse(5);
    wr(8'h10);
    chk(ext_int_o, 8'h01);
    $display("status test done");
    tx_enable_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr({i[1:0], 6'h00});
      chk(rx_crc_init_o, 8'(i == 1));
      chk(tx_crc_init_o, 8'(i == 2));
    end
    sdlc_mode_i <= 1'b1;
    pulse(0);
    chk(rx_crc_init_o, 8'h01);
    @(posedge clk_i);
    rx_enable_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(rx_crc_init_o, 8'h01);
    sdlc_mode_i <= 1'b0;
    wr(8'hC0);
    chk(eom_latch_o, 8'h00);
    pulse(1);
    chk(append_crc_o, 8'h01);
    pulse(2);
    chk(eom_latch_o, 8'h01);
    wr(8'hC0);
    sdlc_mode_i     <= 1'b1;
    abort_on_urun_i <= 1'b1;
    pulse(1);
    chk(send_abort_o, 8'h01);
    wr(8'h18);
    chk({abort_ones_o, tx_flush_o, eom_latch_o}, 8'h07);
    $display("transmit test done");
    wr(8'h20);
    chk(rx_first_arm_o, 8'h01);
    chk(tx_int_o, 8'h01);
    wr(8'h28);
    chk(tx_int_o, 8'h00);
    pulse(4);
    chk(tx_int_o, 8'h01);
    wr(8'h30);
    chk(err_clear_o, 8'h01);
    rx_special_mode_i <= 1'b1;
    pulse(6);
    chk(rx_hold_o, 8'h01);
    wr(8'h30);
    chk(rx_discard_o, 8'h01);
    wr(8'h38);
    chk(ius_clear_o, 8'h01);
    muxed_bus_i <= 1'b1;
    wr(8'h06);
    chk({shift_left_o, shift_right_o, reg_ptr_o}, 8'h20);
    wr(8'h03);
    chk(shift_right_o, 8'h01);
    $display("command test done");
    give_verdict();
  end

  initial begin
    #60000;
    failures++;
    give_verdict();
  end
endmodule : tb_top
